// *** rtl/csfl_core.sv ***
/*
 File holds the command source selection, copy on switching and forced local
 logic of a drive. Assumes channel words, references and network write strobes
 come from logic on the same clock; terminal inputs are asynchronous pins.
*/
// Local design decisions: strobed register access and the placing of the registers.
//
// Overview of operation
// - Switched bit follows selected channel's bit
// - Only bits 11-15 switchable; 11-13 via card
// - Switched and fixed assignment exclude each other
// - Copy ref/cmd to channel 2 per setting
// - No copy: stop until command and reference
// - Copy pre-ramp ref unless up/down speed
// - Terminal command on channel 2: no cmd copy
// - Analog/encoder/frequency ref: no ref copy
// - Forced local only in CiA402 profile
// - Other communication beats forced local
// - Forced local follows chosen input at 1
// - Source: stop, terminals, pulse or panel
// - Local mode rejects network writes
// - Local mode still serves network reads
// - No communication fault during local mode
// - On exit hold run, direction, reference
// - Monitoring resumes after exit delay
// - Act only after reference and command arrive
// - Switched bit counts only on active channel
`timescale 1ns/10ps
`default_nettype none
module csfl_core #(
   parameter int unsigned TICK_CYCLES = csfl_pkg::TICK_CYCLES
) (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output logic      [31:0] reg_rdata_out,
   input  wire logic [13:0] terminal_in,
   input  wire logic        other_comm_active_in,
   input  wire logic        chan2_select_in,
   input  wire logic [15:0] word_ch1_in,
   input  wire logic [15:0] word_ch2_in,
   input  wire logic [15:0] pre_ramp_reference_in,
   input  wire logic [15:0] post_ramp_reference_in,
   input  wire logic [15:0] ch1_cmd_in,
   input  wire logic [15:0] analog_input_2_in,
   input  wire logic [15:0] analog_input_3_in,
   input  wire logic [15:0] analog_input_4_in,
   input  wire logic [15:0] pulse_input_source_in,
   input  wire logic [15:0] panel_speed_reference_in,
   input  wire logic        panel_run_in,
   input  wire logic        panel_dir_in,
   input  wire logic        net_wr_in,
   input  wire logic        net_wr_is_ref_in,
   input  wire logic        net_wr_is_cmd_in,
   input  wire logic        net_rd_in,
   input  wire logic        comm_timeout_in,
   output logic      [4:0]  func_bit_out,
   output logic             net_wr_ack_out,
   output logic             net_wr_nak_out,
   output logic             net_rd_ack_out,
   output logic             comm_fault_out,
   output logic             local_active_out,
   output logic             local_run_out,
   output logic             local_dir_out,
   output logic      [15:0] local_ref_out,
   output logic      [15:0] ch2_ref_out,
   output logic      [15:0] ch2_cmd_out,
   output logic             ch2_load_out,
   output logic             held_valid_out,
   output logic             monitor_en_out,
   output logic             stop_req_out,
   output logic             ctrl_enable_out
);
   // ==========================================================
   // Terminal pins, two flops before use
   logic [13:0] term_s;
   csfl_sync u_sync (
      .mclk_in  (mclk_in),
      .reset_in (reset_in),
      .async_in (terminal_in),
      .sync_out (term_s)
   );

   // ==========================================================
   // Software registers
   logic        cia402_q;
   logic [1:0]  copy_q;
   logic [2:0]  rsrc_q;
   logic        cmdterm_q;
   logic        pcard_q;
   logic [3:0]  sel_q;
   logic [2:0]  src_q;
   logic [4:0]  sw_q;
   logic [4:0]  fix_q;
   logic [2:0]  ext_q;
   logic [15:0] delay_q;

   // Decode of the plain register port
   wire logic       wr_cfg = reg_wr_in && (reg_addr_in == csfl_pkg::ADDR_CFG);
   wire logic       wr_asg = reg_wr_in && (reg_addr_in == csfl_pkg::ADDR_ASSIGN);
   wire logic       wr_dly = reg_wr_in && (reg_addr_in == csfl_pkg::ADDR_DELAY);
   wire logic [4:0] w_sw   = reg_wdata_in[csfl_pkg::ASG_SW_LSB +: 5];
   wire logic [4:0] w_fix  = reg_wdata_in[csfl_pkg::ASG_FIX_LSB +: 5];
   // A position already taken by the other kind is refused bit by bit
   wire logic [4:0] sw_d   = w_sw & ~fix_q;
   wire logic [4:0] fix_d  = w_fix & ~(sw_q | sw_d);

   // Configuration writes
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         cia402_q  <= csfl_pkg::CIA402_RST;
         copy_q    <= csfl_pkg::COPY_NONE;
         rsrc_q    <= csfl_pkg::RSRC_NET;
         cmdterm_q <= 1'b0;
         pcard_q   <= 1'b0;
         sel_q     <= 4'h0;
         src_q     <= csfl_pkg::SRC_STOP;
         sw_q      <= 5'h00;
         fix_q     <= 5'h00;
         ext_q     <= 3'h0;
         delay_q   <= csfl_pkg::DELAY_RST;
      end else begin
         if (wr_cfg) begin
            cia402_q  <= reg_wdata_in[csfl_pkg::CFG_CIA402];
            copy_q    <= reg_wdata_in[csfl_pkg::CFG_COPY_LSB +: 2];
            rsrc_q    <= reg_wdata_in[csfl_pkg::CFG_RSRC_LSB +: 3];
            cmdterm_q <= reg_wdata_in[csfl_pkg::CFG_CMDTERM];
            pcard_q   <= reg_wdata_in[csfl_pkg::CFG_PCARD];
            sel_q     <= reg_wdata_in[csfl_pkg::CFG_SEL_LSB +: 4];
            src_q     <= reg_wdata_in[csfl_pkg::CFG_SRC_LSB +: 3];
         end
         if (wr_asg) begin
            sw_q  <= sw_d;
            fix_q <= fix_d;
            ext_q <= reg_wdata_in[csfl_pkg::ASG_EXT_LSB +: 3];
         end
         if (wr_dly) begin
            delay_q <= reg_wdata_in[15:0];
         end
      end
   end

   // ==========================================================
   // Function bits 11..15; channel 2 may take 11..13 from card inputs 12..14
   logic [4:0] fb_d;
   for (genvar i = 0; i < 5; i++) begin : g_fb
      // Card inputs exist for 11..13 only; the modulo keeps unused indices in range
      wire logic c2 = (i < 3 && ext_q[i % 3]) ? term_s[11 + i % 3]
                                               : word_ch2_in[csfl_pkg::SW_BASE + i];
      wire logic c1 = word_ch1_in[csfl_pkg::SW_BASE + i];
      // Switched bits only count from the channel now active
      assign fb_d[i] = sw_q[i] ? (chan2_select_in ? c2 : c1) : (fix_q[i] & c1);
   end

   // ==========================================================
   // Forced local request and exit sequencing
   csfl_pkg::csfl_state_type st_q;
   csfl_pkg::csfl_state_type st_d;
   logic [31:0] tick_q;
   logic [15:0] dcnt_q;

   // Input 1..14 chosen by the select field, 0 means off
   wire logic sel_hit   = (sel_q != 4'h0) && (sel_q <= 4'he) && term_s[4'(sel_q - 4'h1)];
   // Profile gate and priority of any other communication
   wire logic local_req = cia402_q && sel_hit && !other_comm_active_in;
   wire logic tick      = (tick_q >= TICK_CYCLES - 1);
   wire logic dly_done  = (dcnt_q >= delay_q);
   wire logic exit_ev   = (st_q == csfl_pkg::CSFL_LOCAL) && (st_d != csfl_pkg::CSFL_LOCAL);

   // Next state of the override sequence
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         csfl_pkg::CSFL_REMOTE: begin
            if (local_req) begin
               st_d = csfl_pkg::CSFL_LOCAL;
            end
         end
         csfl_pkg::CSFL_LOCAL: begin
            if (!local_req) begin
               st_d = (delay_q == 16'h0000) ? csfl_pkg::CSFL_REMOTE : csfl_pkg::CSFL_DELAY;
            end
         end
         csfl_pkg::CSFL_DELAY: begin
            if (local_req) begin
               st_d = csfl_pkg::CSFL_LOCAL;
            end else if (dly_done) begin
               st_d = csfl_pkg::CSFL_REMOTE;
            end
         end
      endcase
   end

   // State and exit delay; ticks only run while waiting
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         st_q   <= csfl_pkg::CSFL_REMOTE;
         tick_q <= 32'h0000_0000;
         dcnt_q <= 16'h0000;
      end else begin
         st_q <= st_d;
         if (st_d != csfl_pkg::CSFL_DELAY || st_q != csfl_pkg::CSFL_DELAY) begin
            tick_q <= 32'h0000_0000;
            dcnt_q <= 16'h0000;
         end else if (tick) begin
            tick_q <= 32'h0000_0000;
            dcnt_q <= dcnt_q + 16'h0001;
         end else begin
            tick_q <= tick_q + 32'h0000_0001;
         end
      end
   end

   // ==========================================================
   // Local command and reference; pulse source needs the card
   wire logic pulse_ok = (src_q != csfl_pkg::SRC_PULSE) || pcard_q;
   wire logic run_sel  = (src_q == csfl_pkg::SRC_PANEL) ? panel_run_in : term_s[0];
   wire logic dir_sel  = (src_q == csfl_pkg::SRC_PANEL) ? panel_dir_in : term_s[1];
   wire logic run_loc  = (src_q != csfl_pkg::SRC_STOP) && (src_q <= csfl_pkg::SRC_PANEL)
                         && pulse_ok && run_sel;
   wire logic [15:0] ref_sel =
      (src_q == csfl_pkg::SRC_AI2)                ? analog_input_2_in :
      (src_q == csfl_pkg::SRC_AI3)                ? analog_input_3_in :
      (src_q == csfl_pkg::SRC_AI4)                ? analog_input_4_in :
      (src_q == csfl_pkg::SRC_PULSE && pcard_q)   ? pulse_input_source_in :
      (src_q == csfl_pkg::SRC_PANEL)              ? panel_speed_reference_in :
                                                    16'h0000;

   // ==========================================================
   // Copy on switching to channel 2
   logic chan2_q;
   wire logic sw_edge  = chan2_select_in && !chan2_q;
   wire logic ref_own  = (rsrc_q == csfl_pkg::RSRC_ANALOG) || (rsrc_q == csfl_pkg::RSRC_ENCODER)
                         || (rsrc_q == csfl_pkg::RSRC_FREQ);
   wire logic do_ref   = sw_edge && copy_q[0] && !ref_own;
   wire logic do_cmd   = sw_edge && copy_q[1] && !cmdterm_q;
   // Up/down speed keeps its own ramp, so its output is the one to carry
   wire logic [15:0] ref_cp = (rsrc_q == csfl_pkg::RSRC_UPDOWN) ? post_ramp_reference_in
                                                                 : pre_ramp_reference_in;

   // ==========================================================
   // Waiting for first reference and command; a set beats a clear
   logic aw_ref_q;
   logic aw_cmd_q;
   logic stop_q;
   wire logic local_d  = (st_d == csfl_pkg::CSFL_LOCAL);
   wire logic wr_ok    = net_wr_in && !local_active_out;
   wire logic set_ref  = exit_ev || (sw_edge && !copy_q[0]);
   wire logic set_cmd  = exit_ev || (sw_edge && !copy_q[1]);
   wire logic aw_ref_d = set_ref || (aw_ref_q && !(wr_ok && net_wr_is_ref_in));
   wire logic aw_cmd_d = set_cmd || (aw_cmd_q && !(wr_ok && net_wr_is_cmd_in));
   wire logic aw_any   = aw_ref_d || aw_cmd_d;
   wire logic nocopy   = sw_edge && (copy_q == csfl_pkg::COPY_NONE);
   wire logic stop_d   = nocopy || (stop_q && aw_any);
   wire logic held_d   = exit_ev || (held_valid_out && aw_any);
   // Fault masked in local mode and until monitoring resumes
   wire logic fault_d  = comm_timeout_in && (st_d == csfl_pkg::CSFL_REMOTE);

   // Outputs of the channel logic
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         chan2_q          <= 1'b0;
         func_bit_out     <= 5'h00;
         local_active_out <= 1'b0;
         local_run_out    <= 1'b0;
         local_dir_out    <= 1'b0;
         local_ref_out    <= 16'h0000;
         ch2_ref_out      <= 16'h0000;
         ch2_cmd_out      <= 16'h0000;
         ch2_load_out     <= 1'b0;
         aw_ref_q         <= 1'b0;
         aw_cmd_q         <= 1'b0;
         stop_q           <= 1'b0;
         held_valid_out   <= 1'b0;
         monitor_en_out   <= 1'b1;
         comm_fault_out   <= 1'b0;
         stop_req_out     <= 1'b0;
         ctrl_enable_out  <= 1'b1;
         net_wr_ack_out   <= 1'b0;
         net_wr_nak_out   <= 1'b0;
         net_rd_ack_out   <= 1'b0;
      end else begin
         chan2_q          <= chan2_select_in;
         func_bit_out     <= fb_d;
         local_active_out <= local_d;
         if (local_d) begin
            // Values frozen on exit stay as the held channel values
            local_run_out <= run_loc;
            local_dir_out <= dir_sel;
            local_ref_out <= ref_sel;
         end
         if (do_ref) begin
            ch2_ref_out <= ref_cp;
         end
         if (do_cmd) begin
            ch2_cmd_out <= ch1_cmd_in;
         end
         ch2_load_out     <= do_ref || do_cmd;
         aw_ref_q         <= aw_ref_d;
         aw_cmd_q         <= aw_cmd_d;
         stop_q           <= stop_d;
         held_valid_out   <= held_d;
         monitor_en_out   <= (st_d == csfl_pkg::CSFL_REMOTE);
         comm_fault_out   <= fault_d;
         stop_req_out     <= stop_d || (local_d && !run_loc && src_q == csfl_pkg::SRC_STOP);
         ctrl_enable_out  <= !aw_any && !local_d;
         net_wr_ack_out   <= wr_ok;
         net_wr_nak_out   <= net_wr_in && local_active_out;
         net_rd_ack_out   <= net_rd_in;
      end
   end

   // ==========================================================
   // Read port; data stand only in the cycle after the strobe
   wire logic [31:0] status_w = 32'({chan2_q, held_valid_out, stop_q, aw_cmd_q, aw_ref_q,
                                     monitor_en_out, local_active_out});
   wire logic [31:0] cfg_w    = 32'({src_q, sel_q, pcard_q, cmdterm_q, rsrc_q, copy_q, cia402_q});
   wire logic [31:0] asg_w    = 32'({ext_q, 3'h0, fix_q, 3'h0, sw_q});
   wire logic [31:0] rd_mux   =
      (reg_addr_in == csfl_pkg::ADDR_CFG)    ? cfg_w :
      (reg_addr_in == csfl_pkg::ADDR_ASSIGN) ? asg_w :
      (reg_addr_in == csfl_pkg::ADDR_DELAY)  ? {16'h0000, delay_q} :
      (reg_addr_in == csfl_pkg::ADDR_STATUS) ? status_w : 32'h0000_0000;

   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         reg_rdata_out <= 32'h0000_0000;
      end else begin
         reg_rdata_out <= reg_rd_in ? rd_mux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);

   reject_write_a: assert property (local_active_out && net_wr_in |=> net_wr_nak_out
      && !net_wr_ack_out) else $error("write accepted in local mode");
   serve_read_a: assert property (net_rd_in |=> net_rd_ack_out)
      else $error("read not served");
   fault_mask_a: assert property (local_active_out || !monitor_en_out |-> !comm_fault_out)
      else $error("fault raised in local mode");
   other_prio_a: assert property (other_comm_active_in |=> !local_active_out)
      else $error("local mode beat other communication");
   profile_gate_a: assert property (!cia402_q |=> !local_active_out)
      else $error("local mode outside profile");
   exit_hold_a: assert property ($fell(local_active_out) |-> held_valid_out && !ctrl_enable_out)
      else $error("exit without held values");
   exit_delay_a: assert property ($fell(local_active_out) && delay_q != 16'h0000
      |-> !monitor_en_out[*2]) else $error("monitoring resumed early");
   nocopy_stop_a: assert property (sw_edge && copy_q == csfl_pkg::COPY_NONE
      |=> stop_req_out && !ctrl_enable_out) else $error("no stop after switch");
   sw_exclusive_a: assert property ((sw_q & fix_q) == 5'h00)
      else $error("bit both switched and fixed");
   switched_bit_a: assert property (sw_q[3] && chan2_select_in
      |=> func_bit_out[3] == $past(word_ch2_in[14])) else $error("switched bit wrong");
endmodule
`default_nettype wire

// *** common/csfl_pkg.sv ***
/*
 File holds the shared constants of the command source and forced local block:
 register offsets, field positions, reset values, source codes and timing.
 Assumes a 10 MHz system clock and a word-wide plain register port.
*/
package csfl_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned TICK_MS       = 100;
   localparam int unsigned TICK_CYCLES   = TICK_MS * (CLK_HZ / 1000);
   localparam int unsigned EXIT_DELAY_S  = 10;
   localparam logic [15:0] DELAY_RST     = 16'(EXIT_DELAY_S * 1000 / TICK_MS);

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0]  ADDR_CFG      = 8'h00;
   localparam logic [7:0]  ADDR_ASSIGN   = 8'h04;
   localparam logic [7:0]  ADDR_DELAY    = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0c;

   // ==========================================================
   // Configuration fields
   localparam int          CFG_CIA402    = 0;
   localparam int          CFG_COPY_LSB  = 1;
   localparam int          CFG_RSRC_LSB  = 3;
   localparam int          CFG_CMDTERM   = 6;
   localparam int          CFG_PCARD     = 7;
   localparam int          CFG_SEL_LSB   = 8;
   localparam int          CFG_SRC_LSB   = 12;
   localparam logic        CIA402_RST    = 1'b1;

   // Assignment fields, one bit per switchable position 11..15
   localparam int          SW_BASE       = 11;
   localparam int          ASG_SW_LSB    = 0;
   localparam int          ASG_FIX_LSB   = 8;
   localparam int          ASG_EXT_LSB   = 16;

   // Status fields
   localparam int          ST_LOCAL      = 0;
   localparam int          ST_MON        = 1;
   localparam int          ST_AWREF      = 2;
   localparam int          ST_AWCMD      = 3;
   localparam int          ST_STOP       = 4;
   localparam int          ST_HOLD       = 5;
   localparam int          ST_CH2        = 6;

   // ==========================================================
   // Codes
   localparam logic [1:0]  COPY_NONE     = 2'h0;
   localparam logic [2:0]  RSRC_NET      = 3'h0;
   localparam logic [2:0]  RSRC_UPDOWN   = 3'h1;
   localparam logic [2:0]  RSRC_ANALOG   = 3'h2;
   localparam logic [2:0]  RSRC_ENCODER  = 3'h3;
   localparam logic [2:0]  RSRC_FREQ     = 3'h4;
   localparam logic [2:0]  SRC_STOP      = 3'h0;
   localparam logic [2:0]  SRC_AI2       = 3'h1;
   localparam logic [2:0]  SRC_AI3       = 3'h2;
   localparam logic [2:0]  SRC_AI4       = 3'h3;
   localparam logic [2:0]  SRC_PULSE     = 3'h4;
   localparam logic [2:0]  SRC_PANEL     = 3'h5;

   typedef enum logic [1:0] {
      CSFL_REMOTE,
      CSFL_LOCAL,
      CSFL_DELAY
   } csfl_state_type;
endpackage

// *** rtl/csfl_sync.sv ***
/*
 File holds a two-stage synchroniser for the fourteen terminal inputs.
 Assumes the inputs are asynchronous pins and the clock is the system clock.
*/
`timescale 1ns/10ps
`default_nettype none
module csfl_sync (
   input  wire logic        mclk_in,
   input  wire logic        reset_in,
   input  wire logic [13:0] async_in,
   output logic      [13:0] sync_out
);
   logic [13:0] meta_q;

   // ==========================================================
   // Stage one feeds stage two only
   always_ff @(posedge mclk_in or posedge reset_in) begin
      if (reset_in) begin
         meta_q   <= 14'h0000;
         sync_out <= 14'h0000;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
`default_nettype wire

// *** dv/csfl_net_master.sv ***
/*
 Network master model: issues single writes and reads to the drive and
 takes the one-cycle answer. Assumes the drive's clock and prompt answers.
*/
`timescale 1ns/10ps
`default_nettype none
module csfl_net_master (
   input  wire logic mclk_in,
   input  wire logic wr_ack_in,
   input  wire logic wr_nak_in,
   input  wire logic rd_ack_in,
   output logic      net_wr_out,
   output logic      is_ref_out,
   output logic      is_cmd_out,
   output logic      net_rd_out
);
   // ==========================================================
   // Idle lines at time zero
   initial begin
      net_wr_out = 1'b0;
      net_rd_out = 1'b0;
      is_ref_out = 1'b0;
      is_cmd_out = 1'b0;
   end

   // One request cycle, answer taken the cycle after; qualifiers are
   // inverted when idle so the drive cannot lean on stale values
   task automatic xfer(input logic rd_w, ref_w, cmd_w, output logic [1:0] ans);
      @(posedge mclk_in);
      net_wr_out <= ~rd_w;
      net_rd_out <= rd_w;
      is_ref_out <= ref_w;
      is_cmd_out <= cmd_w;
      @(posedge mclk_in);
      net_wr_out <= 1'b0;
      net_rd_out <= 1'b0;
      is_ref_out <= ~ref_w;
      is_cmd_out <= ~cmd_w;
      #1;
      ans = rd_w ? {rd_ack_in, 1'b0} : {wr_ack_in, wr_nak_in};
   endtask
endmodule
`default_nettype wire

// *** dv/csfl_core_tb_top.sv ***
/*
 Testbench of the command source block: registers, forced local entry and
 exit, copy on switching, switched bits. Assumes a 4-clock delay tick.
*/
`timescale 1ns/10ps
`default_nettype none
module csfl_core_tb_top;
   logic        mclk_in, reset_in, wr, rd, oth, ch2s, tmo, prun, pdir;
   logic        nwr, nref, ncmd, nrd, wack, wnak, rack, flt, lact, lrun, ldir;
   logic        ld, held, mon, stp, cen;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, v;
   logic [13:0] term;
   logic [15:0] w1, w2, pre, post, c1, a2, a3, a4, pls, pnl, lref, c2r, c2c, exp_r, exp_c;
   logic [4:0]  fb;
   logic [1:0]  ans;
   int          bad_count, checked, seed, i, k;

   csfl_core #(.TICK_CYCLES(4)) dut (.mclk_in(mclk_in), .reset_in(reset_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .terminal_in(term), .other_comm_active_in(oth),
      .chan2_select_in(ch2s), .word_ch1_in(w1), .word_ch2_in(w2),
      .pre_ramp_reference_in(pre), .post_ramp_reference_in(post), .ch1_cmd_in(c1),
      .analog_input_2_in(a2), .analog_input_3_in(a3), .analog_input_4_in(a4),
      .pulse_input_source_in(pls), .panel_speed_reference_in(pnl),
      .panel_run_in(prun), .panel_dir_in(pdir), .net_wr_in(nwr),
      .net_wr_is_ref_in(nref), .net_wr_is_cmd_in(ncmd), .net_rd_in(nrd),
      .comm_timeout_in(tmo), .func_bit_out(fb), .net_wr_ack_out(wack),
      .net_wr_nak_out(wnak), .net_rd_ack_out(rack), .comm_fault_out(flt),
      .local_active_out(lact), .local_run_out(lrun), .local_dir_out(ldir),
      .local_ref_out(lref), .ch2_ref_out(c2r), .ch2_cmd_out(c2c), .ch2_load_out(ld),
      .held_valid_out(held), .monitor_en_out(mon), .stop_req_out(stp),
      .ctrl_enable_out(cen));
   csfl_net_master net (.mclk_in(mclk_in), .wr_ack_in(wack), .wr_nak_in(wnak),
      .rd_ack_in(rack), .net_wr_out(nwr), .is_ref_out(nref), .is_cmd_out(ncmd),
      .net_rd_out(nrd));

   // ==========================================================
   // Shared tasks
   task automatic check(input string nm, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(posedge mclk_in);
      #1;
   endtask
   // Register strobes last one cycle; read data stand the cycle after
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ==========================================================
   // Clock and watchdog; the run needs about a hundred cycles
   initial begin
      mclk_in = 1'b0;
      forever #50 mclk_in = ~mclk_in;
   end
   initial begin
      repeat (3000) @(posedge mclk_in);
      bad_count++;
      summarize();
   end

   // ==========================================================
   // Main sequence
   initial begin
      seed = 29209;
      {wr, rd, oth, ch2s, tmo, addr, wdata, term} = '0;
      {w1, w2, pre, post, c1} = 80'({$random(seed), $random(seed), $random(seed)});
      {a2, a3, a4, pls, pnl, prun, pdir} = 82'({$random(seed), $random(seed), $random(seed)});
      reset_in = 1'b1;
      repeat (5) @(posedge mclk_in);
      reset_in <= 1'b0;
      rreg(csfl_pkg::ADDR_DELAY, v);
      check("delay", v, 32'h64);
      rreg(csfl_pkg::ADDR_STATUS, v);
      check("status", v[1:0], 32'h2);
      // Input 3 selects local, AI2 reference; wrong profile first
      wreg(csfl_pkg::ADDR_CFG, 32'h1300);
      term <= 14'h0007;
      ticks(5);
      check("local off", lact, 1'b0);
      wreg(csfl_pkg::ADDR_DELAY, 32'h2);
      wreg(csfl_pkg::ADDR_CFG, 32'h1301);
      ticks(5);
      check("local on", lact, 1'b1);
      check("local ref", lref, a2);
      check("local run", lrun, 1'b1);
      check("local dir", ldir, 1'b1);
      tmo <= 1'b1;
      net.xfer(1'b0, 1'b1, 1'b1, ans);
      check("wr nak", ans, 2'h1);
      net.xfer(1'b1, 1'b0, 1'b0, ans);
      check("rd ack", ans, 2'h2);
      ticks(2);
      check("no fault", flt, 1'b0);
      // Exit: values frozen, monitoring paused for 2 ticks
      term <= 14'h0001;
      ticks(4);
      check("exit", lact, 1'b0);
      check("held", held, 1'b1);
      check("mon paused", mon, 1'b0);
      check("ctrl off", cen, 1'b0);
      term <= 14'h0000;
      ticks(12);
      check("run frozen", lrun, 1'b1);
      check("mon back", mon, 1'b1);
      check("fault", flt, 1'b1);
      tmo <= 1'b0;
      net.xfer(1'b0, 1'b1, 1'b0, ans);
      check("wr ack", ans, 2'h2);
      ticks(2);
      check("ctrl wait", cen, 1'b0);
      net.xfer(1'b0, 1'b0, 1'b1, ans);
      ticks(2);
      check("ctrl on", cen, 1'b1);
      check("held off", held, 1'b0);
      // Other communication overrides local
      term <= 14'h0004;
      ticks(5);
      oth <= 1'b1;
      ticks(2);
      check("other wins", lact, 1'b0);
      oth <= 1'b0;
      term <= 14'h0000;
      // Copy both: pre-ramp, up/down post-ramp, encoder ref kept, terminal cmd kept
      for (i = 0; i < 4; i++) begin
         {pre, post, c1} <= 48'({$random(seed), $random(seed)});
         wreg(csfl_pkg::ADDR_CFG, (i == 3) ? 32'h47 : (i == 2) ? 32'h1f : 32'h7 | (i << 3));
         ch2s <= 1'b1;
         if (i != 2)
            exp_r = (i == 1) ? post : pre;
         if (i != 3)
            exp_c = c1;
         for (k = 0; k < 6 && ld !== 1'b1; k++)
            ticks(1);
         check("load", ld, 1'b1);
         check("copy ref", c2r, exp_r);
         check("copy cmd", c2c, exp_c);
         ch2s <= 1'b0;
         ticks(2);
      end
      wreg(csfl_pkg::ADDR_CFG, 32'h1);
      ch2s <= 1'b1;
      ticks(3);
      check("stop", stp, 1'b1);
      // Switched bits follow the active channel, card inputs on channel 2; fixed dropped
      wreg(csfl_pkg::ADDR_ASSIGN, 32'h0007_1f1f);
      rreg(csfl_pkg::ADDR_ASSIGN, v);
      check("assign", v, 32'h0007_001f);
      for (i = 0; i < 4; i++) begin
         w1 <= 16'($random(seed));
         w2 <= 16'($random(seed));
         term <= 14'($random(seed)) & 14'h3800;
         ch2s <= i[0];
         ticks(3);
         check("func bits", fb, i[0] ? {w2[15:14], term[13:11]} : w1[15:11]);
      end
      summarize();
   end
endmodule
`default_nettype wire
